// file: eipd_pkg.sv
// Purpose : Constants and types shared by the external pin detector.
// Assumes : 32-bit APB, one aligned word per register.
// Notes   : Register word offsets are byte addresses.
package eipd_pkg;
   // Register byte offsets
   localparam logic [7:0] EIPD_SC_OFF     = 8'h00;
   localparam logic [7:0] EIPD_IRQ_ST_OFF = 8'h04;
   localparam logic [7:0] EIPD_IRQ_MK_OFF = 8'h08;
   // Field positions of the status and control register
   localparam int EIPD_BIT_RSVD  = 7;
   localparam int EIPD_BIT_PDD   = 6;
   localparam int EIPD_BIT_EDG   = 5;
   localparam int EIPD_BIT_PE    = 4;
   localparam int EIPD_BIT_FLAG  = 3;
   localparam int EIPD_BIT_ACK   = 2;
   localparam int EIPD_BIT_IE    = 1;
   localparam int EIPD_BIT_MOD   = 0;
   // Reset values
   localparam logic [7:0]  EIPD_SC_RST   = 8'h00;
   localparam logic        EIPD_BIT_RST  = 1'h0;
   localparam logic [31:0] EIPD_ZERO_W   = 32'h0000_0000;
   // Interrupt status bit positions
   localparam int EIPD_EV_DETECT = 0;
   localparam int EIPD_NUM_EV    = 1;
   // Bus response state
   typedef enum logic [0:0] {EIPD_IDLE, EIPD_ACCESS} eipd_bus_type;
endpackage : eipd_pkg

// file: eipd_pin_if.sv
// Purpose : Bundle between the top and the pin detector.
// Assumes : Single pclk domain.
// Notes   : Detector owns the synchroniser and event outputs.
`timescale 1ns/1ps
interface eipd_pin_if;
   logic polarity;  // 1 selects rising / high
   logic enable;    // Pin function enable
   logic asserted;  // Synchronised pin at its asserted level
   logic edge_ev;   // One-cycle pulse on deasserted to asserted
   modport det (input polarity, input enable,
                output asserted, output edge_ev);
   modport ctl (output polarity, output enable,
                input asserted, input edge_ev);
endinterface : eipd_pin_if

// file: eipd_pin_detect.sv
// Purpose : Synchronise the pin and find edges of the selected polarity.
// Assumes : Pin is asynchronous to pclk.
// Notes   : Two flip-flops precede any logic that reads the pin.
`timescale 1ns/1ps
module eipd_pin_detect
   import eipd_pkg::*;
#(
   parameter int SYNC_STAGES = 2
)(
   input  wire logic  pclk,
   input  wire logic  presetn,
   input  wire logic  pin_in,
   eipd_pin_if.det    pif
);
   // Fewer than two stages would let a metastable level reach logic
   if (SYNC_STAGES < 2)
   begin : g_bad_sync
      $error("eipd_pin_detect: SYNC_STAGES must be at least 2");
   end

   logic [SYNC_STAGES-1:0] sync_q;
   logic                   prev_q;
   wire                    pin_s = sync_q[SYNC_STAGES-1];

   // Synchroniser chain; first stage feeds only the next stage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sync_q <= '0;
      else
         sync_q <= {sync_q[SYNC_STAGES-2:0], pin_in};
   end

   // Polarity folds both senses onto one asserted level
   wire asserted_now = pif.enable & (pin_s ~^ pif.polarity);

   // Previous asserted state, cleared while disabled, so enabling
   // onto an asserted pin is taken as an edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prev_q <= EIPD_BIT_RST;
      else
         prev_q <= asserted_now;
   end

   assign pif.asserted = asserted_now;
   assign pif.edge_ev  = asserted_now & ~prev_q;

   AST_EDGE_NEEDS_PRIOR_LOW: assert property (@(posedge pclk)
      disable iff (!presetn) pif.edge_ev |-> !$past(asserted_now))
      else $error("edge reported without prior deasserted level");
   AST_DISABLED_NO_EVENT: assert property (@(posedge pclk)
      disable iff (!presetn) !pif.enable |-> !pif.edge_ev && !pif.asserted)
      else $error("event seen while pin function disabled");
endmodule : eipd_pin_detect

// file: eipd_top.sv
// Purpose : External interrupt pin detector with APB register access.
// Assumes : 32-bit APB slave, pclk 40 MHz, presetn async active low.
// Notes   : Summary of operation below; interrupt status is extra.
//
// Summary of operation
// - Control register bit 7 always reads zero
// - Pull disable bit turns internal pullup off
// - Polarity bit selects falling/low or rising/high
// - Rising polarity with pin enabled forces pullup off
// - Pin enable gates all event detection
// - Event flag read only, shows pending event
// - Writing one to acknowledge clears event flag
// - Acknowledge zero ignored, always reads zero
// - Level mode keeps flag while pin asserted
// - Request enable drives CPU request from flag
// - Mode bit adds level detection to edges
// - Edge means deasserted to asserted transition
`timescale 1ns/1ps
module eipd_top
   import eipd_pkg::*;
#(
   parameter int SYNC_STAGES = 2 // Pin synchroniser depth
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        irq_pin,
   output logic             pullup_en,
   output logic             cpu_irq_req,
   output logic             irq
);
   eipd_pin_if pif ();

   // Control bits
   logic pdd_q, edg_q, pe_q, ie_q, mod_q;
   logic flag_q, flag_d;
   logic [EIPD_NUM_EV-1:0] ist_q, ist_d, imk_q;
   eipd_bus_type           bus_q;

   // Fewer than two stages would let a metastable level reach logic
   if (SYNC_STAGES < 2)
   begin : g_bad_sync
      $error("eipd_top: SYNC_STAGES must be at least 2");
   end

   eipd_pin_detect #(.SYNC_STAGES(SYNC_STAGES)) u_det (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_in  (irq_pin),
      .pif     (pif)
   );

   assign pif.polarity = edg_q;
   assign pif.enable   = pe_q;

   // Bus decode
   wire setup    = psel & ~penable;
   wire access   = psel & penable & pready;
   wire wr_en    = access & pwrite & pstrb[0];
   wire hit_sc   = (paddr == EIPD_SC_OFF);
   wire hit_ist  = (paddr == EIPD_IRQ_ST_OFF);
   wire hit_imk  = (paddr == EIPD_IRQ_MK_OFF);
   wire hit_any  = hit_sc | hit_ist | hit_imk;
   wire wr_sc    = wr_en & hit_sc;
   wire wr_ist   = wr_en & hit_ist;
   wire wr_imk   = wr_en & hit_imk;

   // Acknowledge is a write strobe only, never stored
   wire ack_wr   = wr_sc & pwdata[EIPD_BIT_ACK];

   // Events that set the flag: edges always, level when mode set
   wire level_ev = mod_q & pif.asserted;
   wire set_ev   = pif.edge_ev | level_ev;

   // Set wins over acknowledge so a coincident event is kept
   always_comb
   begin
      flag_d = flag_q;
      if (ack_wr)
         flag_d = 1'b0;
      if (set_ev)
         flag_d = 1'b1;
   end

   // Sticky interrupt status; write one clears, set wins
   always_comb
   begin
      ist_d = ist_q;
      if (wr_ist)
         ist_d = ist_q & ~pwdata[EIPD_NUM_EV-1:0];
      ist_d[EIPD_EV_DETECT] = ist_d[EIPD_EV_DETECT] | set_ev;
   end

   // Control register write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pdd_q <= EIPD_BIT_RST;
         edg_q <= EIPD_BIT_RST;
         pe_q  <= EIPD_BIT_RST;
         ie_q  <= EIPD_BIT_RST;
         mod_q <= EIPD_BIT_RST;
      end
      else if (wr_sc)
      begin
         pdd_q <= pwdata[EIPD_BIT_PDD];
         edg_q <= pwdata[EIPD_BIT_EDG];
         pe_q  <= pwdata[EIPD_BIT_PE];
         ie_q  <= pwdata[EIPD_BIT_IE];
         mod_q <= pwdata[EIPD_BIT_MOD];
      end
   end

   // Flag and interrupt status
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_q <= EIPD_BIT_RST;
         ist_q  <= '0;
         imk_q  <= '0;
      end
      else
      begin
         flag_q <= flag_d;
         ist_q  <= ist_d;
         if (wr_imk)
            imk_q <= pwdata[EIPD_NUM_EV-1:0];
      end
   end

   // Pullup: on only when enabled, not disabled, not rising polarity
   wire pullup_d = pe_q & ~pdd_q & ~edg_q;
   // Request is built from the next flag, so it changes with flag_q and stays registered
   wire cpu_req_d = ie_q & flag_d;
   wire irq_d     = |(ist_d & imk_q);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pullup_en   <= EIPD_BIT_RST;
         cpu_irq_req <= EIPD_BIT_RST;
         irq         <= EIPD_BIT_RST;
      end
      else
      begin
         pullup_en   <= pullup_d;
         cpu_irq_req <= cpu_req_d;
         irq         <= irq_d;
      end
   end

   // Read mux; bit 7 and acknowledge bit are constant zero
   wire [7:0] sc_rd = {1'b0, pdd_q, edg_q, pe_q, flag_q,
                       1'b0, ie_q, mod_q};
   wire [31:0] rd_mux = hit_sc  ? {24'h00_0000, sc_rd} :
                        hit_ist ? {{(32-EIPD_NUM_EV){1'b0}}, ist_q} :
                        hit_imk ? {{(32-EIPD_NUM_EV){1'b0}}, imk_q} :
                        EIPD_ZERO_W;

   // APB: no wait state; pready and prdata come from flops loaded in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bus_q   <= EIPD_IDLE;
         pready  <= 1'b0;
         prdata  <= EIPD_ZERO_W;
         pslverr <= 1'b0;
      end
      else
      begin
         case (bus_q)
            EIPD_IDLE:
            begin
               if (setup)
               begin
                  bus_q   <= EIPD_ACCESS;
                  pready  <= 1'b1;
                  prdata  <= pwrite ? EIPD_ZERO_W : rd_mux;
                  pslverr <= ~hit_any;
               end
            end
            EIPD_ACCESS:
            begin
               bus_q   <= EIPD_IDLE;
               pready  <= 1'b0;
               pslverr <= 1'b0;
            end
            default:
               bus_q <= EIPD_IDLE;
         endcase
      end
   end

   // Checks: register readback
   AST_RSVD_READS_ZERO: assert property (@(posedge pclk)
      disable iff (!presetn) access && !pwrite && hit_sc |->
      prdata[EIPD_BIT_RSVD] == 1'b0)
      else $error("reserved bit read as one");
   AST_ACK_READS_ZERO: assert property (@(posedge pclk)
      disable iff (!presetn) access && !pwrite && hit_sc |->
      prdata[EIPD_BIT_ACK] == 1'b0)
      else $error("acknowledge bit read as one");

   // Checks: pullup control
   // A stale pullup would fight an external pull device on the pin
   AST_PULLUP_RULE: assert property (@(posedge pclk)
      disable iff (!presetn) pe_q && !pdd_q && !edg_q |=> pullup_en)
      else $error("pullup off although enabled");
   AST_PDD_PULLUP_OFF: assert property (@(posedge pclk)
      disable iff (!presetn) pdd_q |=> !pullup_en)
      else $error("pullup on although disabled by software");
   AST_RISING_NO_PULLUP: assert property (@(posedge pclk)
      disable iff (!presetn) pe_q && edg_q |=> !pullup_en)
      else $error("pullup on with rising polarity");
   AST_DISABLED_NO_PULLUP: assert property (@(posedge pclk)
      disable iff (!presetn) !pe_q |=> !pullup_en)
      else $error("pullup on while pin function disabled");

   // Checks: event flag set and clear
   // Set wins, so a clear is only expected with no event pending
   AST_ACK_CLEARS: assert property (@(posedge pclk)
      disable iff (!presetn) ack_wr && !set_ev |=> !flag_q)
      else $error("acknowledge did not clear flag");
   AST_ACK_ZERO_KEEPS: assert property (@(posedge pclk)
      disable iff (!presetn) flag_q && !ack_wr |=> flag_q)
      else $error("flag cleared without acknowledge");
   AST_LEVEL_HOLDS: assert property (@(posedge pclk)
      disable iff (!presetn) mod_q && pif.asserted |=> flag_q)
      else $error("flag clear while level asserted");
   AST_LEVEL_ACK_BLOCKED: assert property (@(posedge pclk)
      disable iff (!presetn) ack_wr && level_ev |=> flag_q)
      else $error("acknowledge cleared flag under held level");
   AST_ACK_LEVEL_CLEARS: assert property (@(posedge pclk)
      disable iff (!presetn) mod_q && ack_wr && !pif.asserted |=> !flag_q)
      else $error("acknowledge ignored after level released");
   AST_EDGE_SETS: assert property (@(posedge pclk)
      disable iff (!presetn) pif.edge_ev |=> flag_q)
      else $error("edge did not set flag");
   AST_EDGE_ONLY_ACK_CLEARS: assert property (@(posedge pclk)
      disable iff (!presetn) !mod_q && ack_wr && !pif.edge_ev |=> !flag_q)
      else $error("edge-only mode kept flag after acknowledge");
   AST_LEVEL_NEEDS_MODE: assert property (@(posedge pclk)
      disable iff (!presetn) set_ev && !pif.edge_ev |-> mod_q)
      else $error("level event in edge-only mode");
   AST_FLAG_CAUSE: assert property (@(posedge pclk)
      disable iff (!presetn) !flag_q ##1 flag_q |->
      $past(set_ev))
      else $error("flag set without event");
   AST_FLAG_READ_ONLY: assert property (@(posedge pclk)
      disable iff (!presetn) wr_sc && !ack_wr && !set_ev |=>
      flag_q == $past(flag_q))
      else $error("control write changed the event flag");
   AST_NO_EV_DISABLED: assert property (@(posedge pclk)
      disable iff (!presetn) !pe_q && !flag_q && !ack_wr |=> !flag_q)
      else $error("flag set while pin disabled");
   AST_FLAG_NEEDS_ENABLE: assert property (@(posedge pclk)
      disable iff (!presetn) !flag_q ##1 flag_q |-> $past(pe_q))
      else $error("flag rose while pin function disabled");
   AST_EDGE_NEEDS_ENABLE: assert property (@(posedge pclk)
      disable iff (!presetn) pif.edge_ev |-> pe_q)
      else $error("edge seen while pin function disabled");
   AST_EDGE_ONE_CYCLE: assert property (@(posedge pclk)
      disable iff (!presetn) pif.edge_ev |=> !pif.edge_ev)
      else $error("held level reported as repeated edges");

   // Checks: CPU request
   // Request is registered from the next flag, so it tracks flag_q
   AST_REQ_FOLLOWS: assert property (@(posedge pclk)
      disable iff (!presetn) ##1 cpu_irq_req == (ie_q && flag_q) ||
      $changed(ie_q) || $changed(flag_q))
      else $error("cpu request does not follow flag");
   AST_REQ_OFF_IE_LOW: assert property (@(posedge pclk)
      disable iff (!presetn) !ie_q |=> !cpu_irq_req)
      else $error("cpu request with request enable clear");
   AST_REQ_TRACKS_FLAG: assert property (@(posedge pclk)
      disable iff (!presetn) ie_q |=> cpu_irq_req == flag_q)
      else $error("cpu request differs from flag");
   AST_REQ_NEEDS_FLAG: assert property (@(posedge pclk)
      disable iff (!presetn) cpu_irq_req |-> flag_q)
      else $error("cpu request without pending flag");

   // Main scenarios reached
   COV_EDGE_EVENT: cover property (@(posedge pclk)
      disable iff (!presetn) pif.edge_ev && !mod_q);
   COV_LEVEL_BLOCKS_ACK: cover property (@(posedge pclk)
      disable iff (!presetn) ack_wr && level_ev);
   COV_REQUEST: cover property (@(posedge pclk)
      disable iff (!presetn) cpu_irq_req && irq);
   COV_RISING_EVENT: cover property (@(posedge pclk)
      disable iff (!presetn) pif.edge_ev && edg_q);
   COV_EXT_PULL_EVENT: cover property (@(posedge pclk)
      disable iff (!presetn) pif.edge_ev && pdd_q);
endmodule : eipd_top

// file: eipd_pin_model.sv
// Purpose : Far-side device driving the external request pin.
// Assumes : Driver changes level only right after a pclk edge.
// Notes   : Released pin goes to pullup or to inverse of last drive.
`timescale 1ns/1ps
module eipd_pin_model (
   input  wire logic pclk,
   input  wire logic drv_en,
   input  wire logic drv_lvl,
   input  wire logic pullup_en,
   output logic      pin
);
   logic last_q;
   // Remember the last driven level so a float never mimics it
   always_ff @(posedge pclk)
   begin
      if (drv_en)
         last_q <= drv_lvl;
   end
   // Undriven without pullup the level is unknown, so show the inverse
   assign pin = drv_en ? drv_lvl : (pullup_en ? 1'b1 : ~last_q);
endmodule : eipd_pin_model

// file: tb_top.sv
// Purpose : Self-checking bench for the external pin detector.
// Assumes : APB master on pclk, pin model on the far side.
// Notes   : Seeded random control words mixed with fixed corners.
`timescale 1ns/1ps
module tb_top;
   import eipd_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat, d, c;
   logic [3:0] pstrb;
   logic irq_pin, pullup_en, cpu_irq_req, irq, drv_en, drv_lvl, rerr;
   int bad_count, num_checks, p;
   eipd_top eipd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .irq_pin(irq_pin), .pullup_en(pullup_en),
      .cpu_irq_req(cpu_irq_req), .irq(irq));
   eipd_pin_model eipd_pin_model_i (.pclk(pclk), .drv_en(drv_en),
      .drv_lvl(drv_lvl), .pullup_en(pullup_en), .pin(irq_pin));
   // Clock at 40 MHz
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task results;
      if (bad_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         bad_count++;
      end
   endtask : chk
   // One APB transfer; waits for pready with no cycle count assumed
   task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= v;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask : rd
   // Pin move then synchroniser, flag and request latency
   task pin(input logic v);
      drv_lvl <= v;
      repeat (5) @(posedge pclk);
   endtask : pin
   // Expected control readback: top bit and acknowledge read zero
   function automatic logic [31:0] exp_sc(logic [31:0] w, logic f);
      return {24'h0, 1'b0, w[6:4], f, 1'b0, w[1:0]};
   endfunction : exp_sc
   initial
   begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      results();
   end
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hF;
      drv_en = 1'b1;
      drv_lvl = 1'b1;
      presetn = 1'b0;
      bad_count = 0;
      num_checks = 0;
      d = $urandom(32'h78810E8D);
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(EIPD_SC_OFF, 32'h0);
      // Random control words with the pin function off, pin toggling
      repeat (8)
      begin
         d = $urandom;
         d[4] = 1'b0;
         drv_lvl <= 1'($urandom);
         apb(1'b1, EIPD_SC_OFF, d);
         rd(EIPD_SC_OFF, exp_sc(d, 1'b0));
      end
      // Pullup against enable, polarity and disable bits
      for (p = 0; p < 8; p++)
      begin
         apb(1'b1, EIPD_SC_OFF, {25'h0, p[2:0], 4'h0});
         repeat (2) @(posedge pclk);
         chk(pullup_en, p[0] & !p[1] & !p[2]);
      end
      // Edge detection in both polarities, acknowledge, wrong direction
      for (p = 0; p < 2; p++)
      begin
         c = 32'h12 | (p << 5);
         pin(!p[0]);
         apb(1'b1, EIPD_SC_OFF, c | 32'h4);
         pin(p[0]);
         rd(EIPD_SC_OFF, exp_sc(c, 1'b1));
         chk(cpu_irq_req, 1'b1);
         apb(1'b1, EIPD_SC_OFF, c | 32'h4);
         rd(EIPD_SC_OFF, exp_sc(c, 1'b0));
         pin(!p[0]);
         rd(EIPD_SC_OFF, exp_sc(c, 1'b0));
      end
      // Level mode: held level defeats acknowledge, no request
      c = 32'h11;
      apb(1'b1, EIPD_SC_OFF, c);
      pin(1'b0);
      apb(1'b1, EIPD_SC_OFF, c | 32'h4);
      rd(EIPD_SC_OFF, exp_sc(c, 1'b1));
      chk(cpu_irq_req, 1'b0);
      pin(1'b1);
      apb(1'b1, EIPD_SC_OFF, c | 32'h4);
      rd(EIPD_SC_OFF, exp_sc(c, 1'b0));
      // Interrupt status, mask and level output
      // Request enable on too, so request and irq are seen together
      apb(1'b1, EIPD_SC_OFF, 32'h12);
      apb(1'b1, EIPD_IRQ_ST_OFF, 32'h1);
      rd(EIPD_IRQ_ST_OFF, 32'h0);
      pin(1'b0);
      rd(EIPD_IRQ_ST_OFF, 32'h1);
      chk(irq, 1'b0);
      apb(1'b1, EIPD_IRQ_MK_OFF, 32'h1);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      chk(cpu_irq_req, 1'b1);
      apb(1'b1, EIPD_IRQ_ST_OFF, 32'h1);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      rd(EIPD_IRQ_MK_OFF, 32'h1);
      // Unmapped address is refused
      apb(1'b0, 8'h0C, 32'h0);
      chk(rerr, 1'b1);
      chk(rdat, 32'h0);
      // Released pin: pullup keeps it high, external pull lets it fall
      pin(1'b1);
      apb(1'b1, EIPD_SC_OFF, 32'h16);
      drv_en <= 1'b0;
      repeat (6) @(posedge pclk);
      chk(pullup_en, 1'b1);
      rd(EIPD_SC_OFF, exp_sc(32'h12, 1'b0));
      apb(1'b1, EIPD_SC_OFF, 32'h52);
      repeat (6) @(posedge pclk);
      chk(pullup_en, 1'b0);
      rd(EIPD_SC_OFF, exp_sc(32'h52, 1'b1));
      chk(cpu_irq_req, 1'b1);
      // Reset in mid-run returns every register to zero
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk(cpu_irq_req, 1'b0);
      chk(pullup_en, 1'b0);
      rd(EIPD_SC_OFF, 32'h0);
      rd(EIPD_IRQ_MK_OFF, 32'h0);
      results();
   end
endmodule : tb_top
